// ### addr_gen_pkg.sv
// Purpose: shared constants and carriers for the indexed/symbolic operand address generator
// Assumes: 20-bit address space, 16-bit instruction words
// Notes:   none
package addr_gen_pkg;
    localparam int ADDR_W      = 20;
    localparam int WORD_W      = 16;
    localparam int EXT_W       = 4;
    // position of the upper nibble within the address
    localparam int UPPER_LSB   = 16;
    localparam int UPPER_MSB   = 19;
    // extension word field positions
    localparam int EXT_SRC_LSB = 7;
    localparam int EXT_DST_LSB = 0;
    localparam int EXT_AL_BIT  = 6;
    // mode codes
    localparam logic [1:0] SRC_MODE_INDEXED = 2'h1;
    localparam logic       DST_MODE_INDEXED = 1'h1;
    localparam logic [1:0] LEN_ADDR_WORD    = 2'h1;   // data-length pair A/L:B/W
    localparam logic [3:0] PC_REG_NUM       = 4'h0;
    localparam logic [3:0] ZERO_NIBBLE      = 4'h0;
    localparam logic [19:0] ADDR_RESET      = 20'h00000;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_SRC  = 2'b01,
        ST_DST  = 2'b11
    } gen_state_t;

    // one instruction as handed over by the decoder
    typedef struct packed {
        logic        isExtended;
        logic [15:0] extWord;
        logic [1:0]  sourceModeCode;
        logic        dstModeBit;
        logic [3:0]  srcBaseNum;
        logic [3:0]  dstBaseNum;
        logic        byteWordBit;
    } instr_info_t;

    // a computed operand address with its kind
    typedef struct packed {
        logic [19:0] addr;
        logic        isDest;
        logic        truncated;
    } operand_addr_t;
endpackage : addr_gen_pkg

// ### base_reg_model.sv
// Purpose: register file and address consumer facing the generator
// Assumes: base values are read combinationally in the take cycle
// Notes:   slow makes the consumer stall every other cycle
`timescale 1ns/1ps
`default_nettype none
module base_reg_model (
    // register reads and address consumer
    input  wire logic        clk,
    input  wire logic        rst_n,
    input  wire logic [3:0]  srcRegSel,
    input  wire logic [3:0]  dstRegSel,
    output logic      [19:0] srcBaseValue,
    output logic      [19:0] dstBaseValue,
    input  wire logic        slow,
    output logic             operandReady
);
    logic [19:0] regs [16];
    logic        stallReg;
    // never written: the generator only reads its bases
    initial begin
        regs = '{default: 20'h5A5A5};
        regs[5] = 20'h0479C;
        regs[6] = 20'h0F778;
        regs[7] = 20'h23456;
        regs[8] = 20'h15678;
        regs[9] = 20'h45678;
    end
    assign srcBaseValue = regs[srcRegSel];
    assign dstBaseValue = regs[dstRegSel];
    always_ff @(posedge clk) stallReg <= rst_n && !stallReg;
    assign operandReady = !slow || stallReg;
endmodule : base_reg_model
`default_nettype wire

// ### index_adder.sv
// Purpose: adds a signed index to a 20-bit base with the legacy/extended truncation choice
// Assumes: purely combinational, no state
// Notes:   base is never written back
`timescale 1ns/1ps
`default_nettype none
module index_adder
    import addr_gen_pkg::*;
(
    // operands
    input  wire logic [19:0] base,
    input  wire logic [15:0] indexLow,
    input  wire logic [3:0]  indexHigh,
    input  wire logic        isExtended,
    // result
    output logic [19:0]      sum,
    output logic             truncated
);
    logic [19:0] indexFull;
    logic [19:0] rawSum;
    logic        baseInLow;

    assign baseInLow = (base[UPPER_MSB:UPPER_LSB] == ZERO_NIBBLE);
    // extended: high nibble from the extension word; legacy: sign-extend
    assign indexFull = isExtended ? {indexHigh, indexLow}
                                  : {{EXT_W{indexLow[WORD_W-1]}}, indexLow};
    // modular 20-bit add wraps silently across the address space
    assign rawSum    = base + indexFull;
    assign truncated = !isExtended && baseInLow;
    // low-64KB legacy case clears the upper nibble; otherwise keep all 20 bits
    assign sum       = truncated ? {ZERO_NIBBLE, rawSum[WORD_W-1:0]}
                                 : rawSum;
endmodule : index_adder
`default_nettype wire

// ### indexed_symbolic_addr_gen.sv
// Purpose: forms source and destination operand addresses for indexed and symbolic modes
// Assumes: decoder presents one instruction at a time; fetch path delivers index words in order
// Notes:   absolute, indirect and immediate modes are handled elsewhere
//
// Summary of operation
// - Legacy indexed with base in the low 64KB clears bits 19:16 of the sum.
// - That truncated case adds the signed 16-bit word after the instruction, giving 00000h-0FFFFh.
// - Legacy indexed with base above 64KB keeps all 20 bits of the sum, so bits 19:16 can differ from the base.
// - That upper case sign-extends the 16-bit index and adds it to all 20 base bits.
// - Upper results span base +/-32KB and may wrap into the low 64KB with no trap.
// - Extended indexed adds a 20-bit index: 4 bits from the extension word, 16 from the next word.
// - Extended indexed address generation never writes back the base register.
// - Upper index bits for source and destination and the A/L bit of the 20-bit flag (pair 01) come from the extension word.
// - Legacy symbolic with the PC in the low 64KB clears bits 19:16 of PC plus index.
// - The symbolic sum only forms an address and leaves the program counter unchanged.
// - Legacy symbolic with the PC above 64KB adds the sign-extended index to all 20 PC bits.
// - Extended symbolic adds the 20-bit PC to the 20-bit index from extension and next word.
// - Source and destination may each be indexed or symbolic, each with its own index word.
// - Indexed is selected by source mode code 01 or destination bit 1; symbolic is indexed on the PC.
`timescale 1ns/1ps
`default_nettype none
module indexed_symbolic_addr_gen
    import addr_gen_pkg::*;
(
    // clock and reset
    input  wire logic          clk,
    input  wire logic          rst_n,
    // decoder side
    input  wire logic          instrValid,
    output logic               instrReady,
    input  wire instr_info_t   instrInfo,
    // index word fetch
    input  wire logic          indexValid,
    output logic               indexReady,
    input  wire logic [15:0]   indexWord,
    input  wire logic [19:0]   indexWordAddr,
    // register file read ports (base values)
    output logic [3:0]         srcRegSel,
    output logic [3:0]         dstRegSel,
    input  wire logic [19:0]   srcBaseValue,
    input  wire logic [19:0]   dstBaseValue,
    // memory address bus
    output operand_addr_t      operandAddr,
    output logic               operandValid,
    input  wire logic          operandReady,
    // status
    output logic               addrWordData,
    output logic               busy
);
    gen_state_t  state_reg, state_next;
    instr_info_t info_reg;
    operand_addr_t outAddr_reg;
    logic        outValid_reg;
    logic        addrWord_reg;

    logic        srcIndexed;
    logic        dstIndexed;
    logic        curIsDest;
    logic        curSymbolic;
    logic [19:0] curBase;
    logic [3:0]  curHigh;
    logic [19:0] sum;
    logic        truncated;
    logic        outFree;
    logic        takeIndex;
    logic        takeInstr;

    // both modes share one encoding; the base number decides symbolic
    assign srcIndexed  = (instrInfo.sourceModeCode == SRC_MODE_INDEXED);
    assign dstIndexed  = (instrInfo.dstModeBit == DST_MODE_INDEXED);

    assign curIsDest   = (state_reg == ST_DST);
    assign srcRegSel   = info_reg.srcBaseNum;
    assign dstRegSel   = info_reg.dstBaseNum;
    assign curSymbolic = curIsDest ? (info_reg.dstBaseNum == PC_REG_NUM)
                                   : (info_reg.srcBaseNum == PC_REG_NUM);
    // symbolic base is the index word's own location, so src and dst differ
    assign curBase     = curSymbolic ? indexWordAddr
                                     : (curIsDest ? dstBaseValue : srcBaseValue);
    // upper index nibbles for each operand live in the extension word
    assign curHigh     = curIsDest ? info_reg.extWord[EXT_DST_LSB +: EXT_W]
                                   : info_reg.extWord[EXT_SRC_LSB +: EXT_W];

    index_adder u_adder (
        .base       (curBase),
        .indexLow   (indexWord),
        .indexHigh  (curHigh),
        .isExtended (info_reg.isExtended),
        .sum        (sum),
        .truncated  (truncated)
    );

    // output stage holds one address; stall index fetch while it is full
    assign outFree    = !outValid_reg || operandReady;
    assign indexReady = (state_reg != ST_IDLE) && outFree;
    assign takeIndex  = indexValid && indexReady;
    assign instrReady = (state_reg == ST_IDLE);
    // instructions without indexed operands are just passed over (one word or none here)
    assign takeInstr  = instrValid && instrReady && (srcIndexed || dstIndexed);

    // one index word per indexed operand: source first, then destination
    always_comb begin
        state_next = state_reg;
        unique case (state_reg)
            ST_IDLE: begin
                if (takeInstr) begin
                    state_next = srcIndexed ? ST_SRC : ST_DST;
                end
            end
            ST_SRC: begin
                if (takeIndex) begin
                    state_next = info_reg.dstModeBit ? ST_DST : ST_IDLE;
                end
            end
            ST_DST: begin
                if (takeIndex) begin
                    state_next = ST_IDLE;
                end
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            state_reg <= ST_IDLE;
        end else begin
            state_reg <= state_next;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            info_reg     <= '0;
            addrWord_reg <= 1'b0;
        end else if (takeInstr) begin
            info_reg     <= instrInfo;
            // 20-bit data needs the extension A/L bit low with B/W high
            addrWord_reg <= instrInfo.isExtended &&
                            ({instrInfo.extWord[EXT_AL_BIT], instrInfo.byteWordBit}
                             == LEN_ADDR_WORD);
        end
    end

    // the result goes only to the address bus; no register is written
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            outValid_reg <= 1'b0;
            outAddr_reg  <= '{addr: ADDR_RESET, isDest: 1'b0, truncated: 1'b0};
        end else if (takeIndex) begin
            outValid_reg <= 1'b1;
            outAddr_reg  <= '{addr: sum, isDest: curIsDest, truncated: truncated};
        end else if (operandReady) begin
            outValid_reg <= 1'b0;
        end
    end

    assign operandAddr  = outAddr_reg;
    assign operandValid = outValid_reg;
    assign addrWordData = addrWord_reg;
    assign busy         = (state_reg != ST_IDLE) || outValid_reg;
endmodule : indexed_symbolic_addr_gen
`default_nettype wire

// ### indexed_symbolic_addr_gen_props.sv
// Purpose: handshake and address checks on the operand address generator
// Assumes: synchronous active-low reset, one clock
// Notes:   bound into every instance of the generator
`timescale 1ns/1ps
`default_nettype none
module addr_gen_props
    import addr_gen_pkg::*;
(
    // watched ports
    input wire logic          clk,
    input wire logic          rst_n,
    input wire logic          instrValid,
    input wire logic          instrReady,
    input wire instr_info_t   instrInfo,
    input wire logic          indexValid,
    input wire logic          indexReady,
    input wire operand_addr_t operandAddr,
    input wire logic          operandValid,
    input wire logic          operandReady,
    input wire logic          busy
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    wire take = instrValid && instrReady
        && (instrInfo.sourceModeCode == SRC_MODE_INDEXED || instrInfo.dstModeBit);
    a_take_locks: assert property (take |=> !instrReady && busy) else $error("no lock");
    a_drop_other: assert property (instrValid && instrReady && !take |=> instrReady)
        else $error("dropped instruction taken");
    a_index_answer: assert property (indexValid && indexReady |=> operandValid)
        else $error("no address after index");
    a_result_holds: assert property (operandValid && !operandReady |=>
        operandValid && $stable(operandAddr)) else $error("address not held");
    a_trunc_low: assert property (operandValid && operandAddr.truncated |->
        operandAddr.addr[19:16] == 4'h0) else $error("truncated address high");
    a_full_refuse: assert property (operandValid && !operandReady |-> !indexReady)
        else $error("index taken while full");
    a_phase_excl: assert property (instrReady |-> !indexReady) else $error("both ready");
    a_idle_quiet: assert property (!busy |-> instrReady && !operandValid)
        else $error("idle but active");
endmodule : addr_gen_props
bind indexed_symbolic_addr_gen addr_gen_props props(.clk(clk), .rst_n(rst_n),
    .instrValid(instrValid), .instrReady(instrReady), .instrInfo(instrInfo),
    .indexValid(indexValid), .indexReady(indexReady), .operandAddr(operandAddr),
    .operandValid(operandValid), .operandReady(operandReady), .busy(busy));
`default_nettype wire

// ### indexed_symbolic_addr_gen_tb_top.sv
// Purpose: self-checking bench for the operand address generator
// Assumes: one instruction in flight, each address consumed before the next index
// Notes:   expected word is {addr, isDest, truncated}
`timescale 1ns/1ps
`default_nettype none
module indexed_symbolic_addr_gen_tb_top import addr_gen_pkg::*;;
    logic          clk = 0, rst_n = 0, instrValid = 0, indexValid = 0, slow = 0;
    logic          instrReady, indexReady, operandValid, operandReady, addrWordData, busy;
    instr_info_t   instrInfo = '0;
    logic [15:0]   indexWord = '0;
    logic [19:0]   indexWordAddr = '0, srcBaseValue, dstBaseValue;
    logic [3:0]    srcRegSel, dstRegSel;
    operand_addr_t operandAddr;
    int            errors = 0, checks = 0;
    always #5 clk = ~clk;
    indexed_symbolic_addr_gen dut(.clk(clk), .rst_n(rst_n), .instrValid(instrValid),
        .instrReady(instrReady), .instrInfo(instrInfo), .indexValid(indexValid),
        .indexReady(indexReady), .indexWord(indexWord), .indexWordAddr(indexWordAddr),
        .srcRegSel(srcRegSel), .dstRegSel(dstRegSel), .srcBaseValue(srcBaseValue),
        .dstBaseValue(dstBaseValue), .operandAddr(operandAddr), .operandValid(operandValid),
        .operandReady(operandReady), .addrWordData(addrWordData), .busy(busy));
    base_reg_model far(.clk(clk), .rst_n(rst_n), .srcRegSel(srcRegSel), .dstRegSel(dstRegSel),
        .srcBaseValue(srcBaseValue), .dstBaseValue(dstBaseValue), .slow(slow),
        .operandReady(operandReady));
    task automatic check(input logic [21:0] seen, input logic [21:0] exp);
        checks++;
        if (seen !== exp) begin
            errors++;
            $display("Error %0t: got %h want %h", $time, seen, exp);
        end
    endtask : check
    task automatic report_and_stop();
        $display("checks %0d errors %0d", checks, errors);
        if (errors == 0 && checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : report_and_stop
    task automatic offer(input instr_info_t info);
        int n = 0;
        instrInfo <= info;
        instrValid <= 1'b1;
        do @(posedge clk); while (!instrReady && n++ < 50);
        instrValid <= 1'b0;
        if (n > 50) begin
            errors++;
            $display("Error %0t: instruction never taken", $time);
        end
    endtask : offer
    task automatic xfer(input logic [15:0] w, input logic [19:0] wa, input logic [21:0] exp);
        int n = 0;
        indexWord <= w;
        indexWordAddr <= wa;
        indexValid <= 1'b1;
        do @(posedge clk); while (!indexReady && n++ < 50);
        indexValid <= 1'b0;
        do @(posedge clk); while (!(operandValid && operandReady) && n++ < 50);
        if (n > 50) begin
            errors++;
            $display("Error %0t: index or address handshake stuck", $time);
        end
        check(operandAddr, exp);
    endtask : xfer
    task automatic t_idx();
        offer('{1'b0, 16'h0000, 2'h1, 1'b1, 4'h5, 4'h6, 1'b0});
        xfer(16'h1000, 20'h01002, {20'h0579C, 2'b01});
        xfer(16'h1000, 20'h01004, {20'h00778, 2'b11});
        slow <= 1'b1;
        offer('{1'b0, 16'h0000, 2'h1, 1'b1, 4'h7, 4'h8, 1'b0});
        xfer(16'h8346, 20'h21002, {20'h1B79C, 2'b00});
        xfer(16'h2100, 20'h21004, {20'h17778, 2'b10});
    endtask : t_idx
    task automatic t_drop();
        offer('{1'b0, 16'h0000, 2'h0, 1'b0, 4'h7, 4'h8, 1'b0});
        @(posedge clk);
        check({20'h0, instrReady, busy}, 22'h2);
        offer('{1'b0, 16'h0000, 2'h1, 1'b0, 4'h8, 4'h8, 1'b0});
        xfer(16'h2100, 20'h21002, {20'h17778, 2'b00});
        @(posedge clk);
        check({20'h0, instrReady, busy}, 22'h2);
        offer('{1'b0, 16'h0000, 2'h3, 1'b1, 4'h7, 4'h6, 1'b0});
        xfer(16'h1000, 20'h01002, {20'h00778, 2'b11});
    endtask : t_drop
    task automatic t_sym();
        offer('{1'b0, 16'h0000, 2'h1, 1'b1, 4'h0, 4'h0, 1'b0});
        xfer(16'h4766, 20'h01036, {20'h0579C, 2'b01});
        xfer(16'hF740, 20'h01038, {20'h00778, 2'b11});
        offer('{1'b0, 16'h0000, 2'h1, 1'b1, 4'h0, 4'h0, 1'b0});
        xfer(16'h4766, 20'h2F036, {20'h3379C, 2'b00});
        xfer(16'h8000, 20'h10010, {20'h08010, 2'b10});
    endtask : t_sym
    task automatic t_ext();
        offer('{1'b1, 16'h0083, 2'h1, 1'b1, 4'h7, 4'h9, 1'b1});
        xfer(16'h2346, 20'h30002, {20'h3579C, 2'b00});
        check({21'h0, addrWordData}, 22'h1);
        xfer(16'h2100, 20'h30004, {20'h77778, 2'b10});
        offer('{1'b1, 16'h0085, 2'h1, 1'b1, 4'h0, 4'h0, 1'b0});
        xfer(16'h4766, 20'h21036, {20'h3579C, 2'b00});
        check({21'h0, addrWordData}, 22'h0);
        xfer(16'h6740, 20'h21038, {20'h77778, 2'b10});
    endtask : t_ext
    task automatic t_reset();
        offer('{1'b1, 16'h0083, 2'h1, 1'b1, 4'h7, 4'h9, 1'b1});
        // drop reset while an instruction is in flight
        rst_n <= 1'b0;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        check(operandAddr, 22'h0);
        check({18'h0, instrReady, indexReady, operandValid, busy}, 22'h8);
        check({21'h0, addrWordData}, 22'h0);
        offer('{1'b0, 16'h0000, 2'h1, 1'b0, 4'h0, 4'h0, 1'b0});
        xfer(16'h4766, 20'h01036, {20'h0579C, 2'b01});
    endtask : t_reset
    initial begin
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        check({18'h0, instrReady, indexReady, operandValid, busy}, 22'h8);
        check(operandAddr, 22'h0);
        t_idx();
        t_drop();
        t_sym();
        t_ext();
        t_reset();
        report_and_stop();
    end
    initial begin
        repeat (2000) @(posedge clk);
        errors++;
        report_and_stop();
    end
endmodule : indexed_symbolic_addr_gen_tb_top
`default_nettype wire
